// >>> hw/pps_stage.sv
// Programmable protection stage, top level with Wishbone registers.
// Assumes the measurement unit presents NSIG signed quantities, held
// stable between updates, synchronous to i_ref_clk.
//
// Overview of operation
// - Selection A is the supervised quantity, and operand one in difference modes.
// - Selection B is used only as operand two in difference modes.
// - Four modes: over, under, difference and magnitude of difference.
// - Pick-up limit is a setting scaled to the selected signal.
// - Trip only after the definite-time delay with condition held.
// - Under mode ignores values below the floor; no fault there.
//
// Our own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pps_stage
   import pps_pkg::*;
#(
   parameter int W = 32,
   parameter int NSIG = 32,
   parameter int BASE_CYC = PPS_BASE_TICK_CYC
)
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // Wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // Measured quantities, flattened
   input wire logic [NSIG*W-1:0] i_meas,
   // Stage outputs
   output logic o_start,
   output logic o_trip,
   output logic o_irq
);
   // ==========================================================
   // State
   typedef struct packed
   {
      logic [31:0] ctrl;
      logic [31:0] pickup;
      logic [31:0] hyst;
      logic [31:0] floor_lvl;
      logic [31:0] delay;
      logic [31:0] elapsed;
      logic [PPS_IRQ_W-1:0] irq;
      logic [PPS_IRQ_W-1:0] mask;
      logic [31:0] value;
      logic [31:0] rdat;
      logic ack;
      logic start;
      logic trip;
      logic irq_out;
   } pps_top_s;
   pps_top_s st;
   pps_top_s next_st;

   logic tick;
   logic cond;
   logic signed [W:0] cmp_value;
   logic [W-1:0] op_a;
   logic [W-1:0] op_b;
   logic [1:0] mode;
   logic [7:0] sel_a;
   logic [7:0] sel_b;
   logic wb_req;
   logic [PPS_IRQ_W-1:0] evt;

   // Byte-lane merge for register writes.
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
            r[i*8 +: 8] = new_v[i*8 +: 8];
      end
      return r;
   endfunction

   // Pick a measured quantity; out-of-range selections give zero.
   function automatic logic [W-1:0] pick_sig(input logic [NSIG*W-1:0] bus,
                                             input logic [7:0] idx);
      logic [W-1:0] r;
      r = '0;
      for (int i = 0; i < NSIG; i++)
      begin
         if (int'(idx) == i)
            r = bus[i*W +: W];
      end
      return r;
   endfunction

   // ==========================================================
   // Field decode and operand selection
   assign mode = st.ctrl[PPS_CTRL_MODE_LSB +: 2];
   assign sel_a = st.ctrl[PPS_CTRL_SELA_LSB +: 8];
   assign sel_b = st.ctrl[PPS_CTRL_SELB_LSB +: 8];
   assign op_a = pick_sig(i_meas, sel_a);
   assign op_b = pick_sig(i_meas, sel_b);
   assign wb_req = i_wb_cyc && i_wb_stb && !st.ack;

   // Evaluation tick divider.
   pps_tick_div #(
      .BASE_CYC(BASE_CYC)
   ) u_div (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_run(st.ctrl[PPS_CTRL_EN_BIT]),
      .i_tick_sel(st.ctrl[PPS_CTRL_TICK_LSB +: 2]),
      .o_tick(tick)
   );

   // Comparator with dead band.
   pps_compare #(
      .W(W)
   ) u_cmp (
      .i_mode(mode),
      .i_limit(st.pickup[W-1:0]),
      .i_hyst(st.hyst[W-1:0]),
      .i_floor(st.floor_lvl[W-1:0]),
      .i_picked(st.start),
      .i_op_a(op_a),
      .i_op_b(op_b),
      .o_cond(cond),
      .o_value(cmp_value)
   );

   // ==========================================================
   // Next-state logic
   always_comb
   begin
      next_st = st;
      evt = '0;
      next_st.ack = 1'b0;
      // Stage evaluation at each tick.
      if (!st.ctrl[PPS_CTRL_EN_BIT])
      begin
         next_st.start = 1'b0;
         next_st.trip = 1'b0;
         next_st.elapsed = 32'h0000_0000;
      end
      else if (tick)
      begin
         next_st.value = 32'(cmp_value);
         if (cond)
         begin
            next_st.start = 1'b1;
            evt[PPS_IRQ_START] = !st.start;
            if (st.elapsed >= st.delay)
            begin
               next_st.trip = 1'b1;
               evt[PPS_IRQ_TRIP] = !st.trip;
            end
            else
            begin
               next_st.elapsed = st.elapsed + 32'h0000_0001;
            end
         end
         else
         begin
            next_st.start = 1'b0;
            next_st.trip = 1'b0;
            next_st.elapsed = 32'h0000_0000;
            evt[PPS_IRQ_RELEASE] = st.start;
         end
      end
      // Register access; an interrupt register read clears it, new events win.
      if (wb_req)
      begin
         next_st.ack = 1'b1;
         next_st.rdat = 32'h0000_0000;
         case (i_wb_adr)
            PPS_OFS_CTRL: next_st.rdat = st.ctrl;
            PPS_OFS_PICKUP: next_st.rdat = st.pickup;
            PPS_OFS_HYST: next_st.rdat = st.hyst;
            PPS_OFS_FLOOR: next_st.rdat = st.floor_lvl;
            PPS_OFS_DELAY: next_st.rdat = st.delay;
            PPS_OFS_STATUS: next_st.rdat = {30'h0000_0000, st.trip, st.start};
            PPS_OFS_IRQ: next_st.rdat = 32'(st.irq);
            PPS_OFS_MASK: next_st.rdat = 32'(st.mask);
            PPS_OFS_VALUE: next_st.rdat = st.value;
            default: next_st.rdat = 32'h0000_0000;
         endcase
         if (i_wb_we)
         begin
            case (i_wb_adr)
               PPS_OFS_CTRL: next_st.ctrl = merge_bytes(st.ctrl, i_wb_dat, i_wb_sel);
               PPS_OFS_PICKUP: next_st.pickup = merge_bytes(st.pickup, i_wb_dat, i_wb_sel);
               PPS_OFS_HYST: next_st.hyst = merge_bytes(st.hyst, i_wb_dat, i_wb_sel);
               PPS_OFS_FLOOR: next_st.floor_lvl = merge_bytes(st.floor_lvl, i_wb_dat, i_wb_sel);
               PPS_OFS_DELAY: next_st.delay = merge_bytes(st.delay, i_wb_dat, i_wb_sel);
               PPS_OFS_MASK:
                  next_st.mask = PPS_IRQ_W'(merge_bytes(32'(st.mask), i_wb_dat, i_wb_sel));
               default: next_st.rdat = next_st.rdat;
            endcase
         end
         else if (i_wb_adr == PPS_OFS_IRQ)
         begin
            next_st.irq = '0;
         end
      end
      next_st.irq = next_st.irq | evt;
      next_st.irq_out = |(next_st.irq & next_st.mask);
   end

   // State register.
   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         st <= '0;
         st.ctrl <= PPS_CTRL_RESET;
         st.pickup <= PPS_PICKUP_RESET;
         st.hyst <= PPS_HYST_RESET;
         st.floor_lvl <= PPS_FLOOR_RESET;
         st.delay <= PPS_DELAY_RESET;
         st.mask <= PPS_IRQ_W'(PPS_MASK_RESET);
      end
      else
      begin
         st <= next_st;
      end
   end

   // Outputs straight from flip-flops.
   assign o_wb_dat = st.rdat;
   assign o_wb_ack = st.ack;
   assign o_start = st.start;
   assign o_trip = st.trip;
   assign o_irq = st.irq_out;
endmodule
`default_nettype wire

// >>> hw/pps_pkg.sv
// Package for the programmable protection stage.
// Assumes a 100 MHz system clock and a classic Wishbone register bus.
package pps_pkg;
   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] PPS_OFS_CTRL = 8'h00;
   localparam logic [7:0] PPS_OFS_PICKUP = 8'h04;
   localparam logic [7:0] PPS_OFS_HYST = 8'h08;
   localparam logic [7:0] PPS_OFS_FLOOR = 8'h0C;
   localparam logic [7:0] PPS_OFS_DELAY = 8'h10;
   localparam logic [7:0] PPS_OFS_STATUS = 8'h14;
   localparam logic [7:0] PPS_OFS_IRQ = 8'h18;
   localparam logic [7:0] PPS_OFS_MASK = 8'h1C;
   localparam logic [7:0] PPS_OFS_VALUE = 8'h20;
   // ==========================================================
   // Control register fields
   localparam int PPS_CTRL_EN_BIT = 0;
   localparam int PPS_CTRL_MODE_LSB = 1;
   localparam int PPS_CTRL_TICK_LSB = 3;
   localparam int PPS_CTRL_SELA_LSB = 8;
   localparam int PPS_CTRL_SELB_LSB = 16;
   localparam logic [31:0] PPS_CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] PPS_PICKUP_RESET = 32'h0000_0000;
   localparam logic [31:0] PPS_HYST_RESET = 32'h0000_0000;
   localparam logic [31:0] PPS_FLOOR_RESET = 32'h0000_0000;
   localparam logic [31:0] PPS_DELAY_RESET = 32'h0000_0000;
   localparam logic [31:0] PPS_MASK_RESET = 32'h0000_0000;
   // Interrupt bits: start rise, trip rise, start fall.
   localparam int PPS_IRQ_START = 0;
   localparam int PPS_IRQ_TRIP = 1;
   localparam int PPS_IRQ_RELEASE = 2;
   localparam int PPS_IRQ_W = 3;
   // ==========================================================
   // Comparison modes
   typedef enum logic [1:0]
   {
      PPS_MODE_OVER = 2'h0,
      PPS_MODE_UNDER = 2'h1,
      PPS_MODE_DIFF = 2'h2,
      PPS_MODE_MAG_DIFF = 2'h3
   } pps_mode_e;
   // Evaluation tick choices
   localparam logic [1:0] PPS_TICK_10MS = 2'h0;
   localparam logic [1:0] PPS_TICK_20MS = 2'h1;
   localparam logic [1:0] PPS_TICK_100MS = 2'h2;
   // ==========================================================
   // Timing
   localparam int PPS_CLK_HZ = 100_000_000;
   localparam int PPS_BASE_TICK_US = 10_000;
   localparam int PPS_BASE_TICK_CYC = PPS_CLK_HZ / 1_000_000 * PPS_BASE_TICK_US;
   localparam int PPS_TICKS_10MS = 1;
   localparam int PPS_TICKS_20MS = 2;
   localparam int PPS_TICKS_100MS = 10;
endpackage

// >>> hw/pps_tick_div.sv
// Divider making a one-cycle evaluation tick pulse.
// Assumes the count parameter is shortened in simulation.
`timescale 1ns/1ps
`default_nettype none
module pps_tick_div
   import pps_pkg::*;
#(
   parameter int BASE_CYC = PPS_BASE_TICK_CYC
)
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // Control
   input wire logic i_run,
   input wire logic [1:0] i_tick_sel,
   // Tick out
   output logic o_tick
);
   typedef struct packed
   {
      logic [31:0] base;
      logic [3:0] sub;
      logic tick;
   } pps_div_s;
   pps_div_s st;
   pps_div_s next_st;
   logic [3:0] sub_max;

   // Number of base periods per evaluation tick.
   always_comb
   begin
      case (i_tick_sel)
         PPS_TICK_20MS: sub_max = 4'(PPS_TICKS_20MS - 1);
         PPS_TICK_100MS: sub_max = 4'(PPS_TICKS_100MS - 1);
         default: sub_max = 4'(PPS_TICKS_10MS - 1);
      endcase
   end

   // Base counter and sub-count produce the tick.
   always_comb
   begin
      next_st = st;
      next_st.tick = 1'b0;
      if (!i_run)
      begin
         next_st.base = 32'h0000_0000;
         next_st.sub = 4'h0;
      end
      else if (st.base >= 32'(BASE_CYC - 1))
      begin
         next_st.base = 32'h0000_0000;
         if (st.sub >= sub_max)
         begin
            next_st.sub = 4'h0;
            next_st.tick = 1'b1;
         end
         else
         begin
            next_st.sub = st.sub + 4'h1;
         end
      end
      else
      begin
         next_st.base = st.base + 32'h0000_0001;
      end
   end

   // State register.
   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         st <= '0;
      else
         st <= next_st;
   end

   assign o_tick = st.tick;
endmodule
`default_nettype wire

// >>> hw/pps_compare.sv
// Comparison unit: picks operands and decides pick-up with dead band.
// Assumes signed measured quantities in a common scale per selection.
`timescale 1ns/1ps
`default_nettype none
module pps_compare
   import pps_pkg::*;
#(
   parameter int W = 32
)
(
   // Settings
   input wire logic [1:0] i_mode,
   input wire logic signed [W-1:0] i_limit,
   input wire logic signed [W-1:0] i_hyst,
   input wire logic signed [W-1:0] i_floor,
   input wire logic i_picked,
   // Operands
   input wire logic signed [W-1:0] i_op_a,
   input wire logic signed [W-1:0] i_op_b,
   // Results
   output logic o_cond,
   output logic signed [W:0] o_value
);
   logic signed [W:0] val;
   logic signed [W:0] lim;
   logic signed [W:0] hys;
   logic signed [W:0] flo;

   // Operand choice, limit test and hysteresis.
   always_comb
   begin
      lim = {i_limit[W-1], i_limit};
      hys = {i_hyst[W-1], i_hyst};
      // A concatenation is unsigned, so the floor goes through a signed variable first.
      flo = {i_floor[W-1], i_floor};
      val = {i_op_a[W-1], i_op_a};
      o_cond = 1'b0;
      case (pps_mode_e'(i_mode))
         PPS_MODE_OVER: o_cond = i_picked ? (val > lim - hys) : (val > lim);
         PPS_MODE_UNDER:
         begin
            if (val >= flo)
               o_cond = i_picked ? (val < lim + hys) : (val < lim);
         end
         PPS_MODE_DIFF:
         begin
            val = {i_op_a[W-1], i_op_a} - {i_op_b[W-1], i_op_b};
            o_cond = i_picked ? (val > lim - hys) : (val > lim);
         end
         default:
         begin
            val = {i_op_a[W-1], i_op_a} - {i_op_b[W-1], i_op_b};
            if (val < 0)
               val = -val;
            o_cond = i_picked ? (val > lim - hys) : (val > lim);
         end
      endcase
      o_value = val;
   end
endmodule
`default_nettype wire

// >>> bench/pps_meas_model.sv
// Model of the measurement unit feeding the protection stage.
// Assumes the bench picks which channels hold steady values.
`timescale 1ns/1ps
`default_nettype none
module pps_meas_model
#(
   parameter int W = 32,
   parameter int NSIG = 32
)
(
   // Clock
   input wire logic i_ref_clk,
   // Quantities
   output logic [NSIG*W-1:0] o_meas
);
   logic [W-1:0] held [NSIG];
   logic [NSIG-1:0] live = '0;
   // Sets channel k to a steady value from the next edge on.
   task automatic put(input int k, input int v);
      held[k] = W'(v);
      live[k] = 1'b1;
   endtask
   // Channels nobody set change every cycle, so a wrong pick shows up.
   always @(posedge i_ref_clk)
   begin
      for (int k = 0; k < NSIG; k++)
         o_meas[k*W +: W] <= live[k] ? held[k] : W'($urandom);
   end
endmodule
`default_nettype wire

// >>> bench/pps_stage_assertions.sv
// Checker on the ports of the protection stage.
// Assumes it is bound with the tick base the bench uses.
`timescale 1ns/1ps
`default_nettype none
module pps_stage_checker
   import pps_pkg::*;
#(
   parameter int W = 32,
   parameter int NSIG = 32,
   parameter int BASE_CYC = 10
)
(
   // Clock, reset and bus
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   input wire logic [31:0] o_wb_dat,
   input wire logic o_wb_ack,
   // Stage
   input wire logic [NSIG*W-1:0] i_meas,
   input wire logic o_start,
   input wire logic o_trip,
   input wire logic o_irq
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_sys_rst);
   // ====================
   // Bus steps: a request is taken, then one ack pulse follows.
   sequence s_take;
      i_wb_cyc && i_wb_stb && !o_wb_ack;
   endsequence
   sequence s_answer;
      o_wb_ack ##1 !o_wb_ack;
   endsequence
   sequence s_read(logic [7:0] a);
      o_wb_ack && !i_wb_we && i_wb_adr == a;
   endsequence
   a_ack_timing: assert property (s_take |=> s_answer)
      else $error("ack not one cycle after request");
   a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
      else $error("ack without request");
   a_unmapped_zero: assert property (
      o_wb_ack && !i_wb_we && i_wb_adr > PPS_OFS_VALUE |-> o_wb_dat == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_status_read: assert property (
      s_read(PPS_OFS_STATUS) |-> o_wb_dat == {30'h0000_0000, $past(o_trip), $past(o_start)})
      else $error("status read wrong");
   a_trip_start: assert property (o_trip |-> o_start)
      else $error("trip without start");
   a_trip_wait: assert property (
      $rose(o_trip) && $past(o_start) |-> $past(o_start, BASE_CYC - 1))
      else $error("trip too soon after start");
   a_trip_drop: assert property ($fell(o_trip) |-> !o_start)
      else $error("trip dropped while started");
   a_start_hold: assert property ($rose(o_start) |=> o_start[*8])
      else $error("start dropped between ticks");
endmodule
bind pps_stage pps_stage_checker #(.W(W), .NSIG(NSIG), .BASE_CYC(BASE_CYC)) u_chk (
   .i_ref_clk(i_ref_clk),
   .i_sys_rst(i_sys_rst),
   .i_wb_cyc(i_wb_cyc),
   .i_wb_stb(i_wb_stb),
   .i_wb_we(i_wb_we),
   .i_wb_adr(i_wb_adr),
   .i_wb_sel(i_wb_sel),
   .i_wb_dat(i_wb_dat),
   .o_wb_dat(o_wb_dat),
   .o_wb_ack(o_wb_ack),
   .i_meas(i_meas),
   .o_start(o_start),
   .o_trip(o_trip),
   .o_irq(o_irq)
);
`default_nettype wire

// >>> bench/tb_programmable_protection_stage.sv
// Self-checking bench for the protection stage.
// Assumes a 10-cycle tick base and the measurement model beside it.
`timescale 1ns/1ps
`default_nettype none
module tb_programmable_protection_stage;
   import pps_pkg::*;
   localparam int BASE = 10;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = '0;
   logic [3:0] sel = 4'hF;
   logic [31:0] wdat = '0;
   logic [31:0] rdat, q;
   logic ack, start, trip, irq;
   logic [32*32-1:0] meas;
   int failures = 0;
   int samples_checked = 0;
   int per_q[$] = '{BASE, 2*BASE, 10*BASE};
   logic [7:0] offs[4] = '{PPS_OFS_PICKUP, PPS_OFS_HYST, PPS_OFS_FLOOR, PPS_OFS_DELAY};
   pps_meas_model u_meas (.i_ref_clk(ref_clk), .o_meas(meas));
   pps_stage #(.BASE_CYC(BASE)) u_dut (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst),
      .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
      .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_meas(meas),
      .o_start(start), .o_trip(trip), .o_irq(irq));
   // Clock of 10 ns.
   initial
   begin
      forever #5 ref_clk = ~ref_clk;
   end
   // Compares and counts.
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One classic bus cycle; read data lands in q.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      // Ack stands in the cycle after the request is taken.
      chk("bus latency", n, 2);
   endtask
   task automatic end_sim();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   function automatic int rnd();
      return int'($urandom_range(200)) - 100;
   endfunction
   // Reference value: A, A minus B, or its magnitude.
   function automatic int expv(int m, int a, int b);
      return (m < 2) ? a : (m == 2 || a > b) ? a - b : b - a;
   endfunction
   // Hang guard.
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      end_sim();
   end
   // Main sequence.
   initial
   begin
      int a, b, lim, fl, n, v;
      logic e;
      void'($urandom(67506));
      repeat (20) @(posedge ref_clk);
      sys_rst <= 1'b0;
      foreach (offs[i])
      begin
         wb(0, offs[i], 0);
         chk("reset value", q, 32'h0000_0000);
         v = $urandom;
         wb(1, offs[i], v);
         wb(0, offs[i], 0);
         chk("readback", q, v);
      end
      wb(0, PPS_OFS_CTRL, 0);
      chk("ctrl reset", q, PPS_CTRL_RESET);
      wb(1, 8'h40, $urandom);
      wb(0, 8'h40, 0);
      chk("unmapped", q, 0);
      wb(1, PPS_OFS_STATUS, 3);
      wb(0, PPS_OFS_STATUS, 0);
      chk("status ro", q, 0);
      $display("register test done");
      for (int m = 0; m < 4; m++)
      begin
         for (int r = 0; r < 3; r++)
         begin
            a = rnd() | 1;
            b = rnd() & ~1;
            lim = rnd() & ~1;
            fl = rnd() & ~1;
            v = expv(m, a, b);
            e = (m == 1) ? (a < lim && a >= fl) : (v > lim);
            u_meas.put(3, a);
            u_meas.put(7, b);
            wb(1, PPS_OFS_PICKUP, lim);
            wb(1, PPS_OFS_HYST, 0);
            wb(1, PPS_OFS_FLOOR, fl);
            wb(1, PPS_OFS_DELAY, 0);
            wb(1, PPS_OFS_CTRL, 1 | m << 1 | 3 << 8 | 7 << 16);
            repeat (25) @(posedge ref_clk);
            wb(0, PPS_OFS_STATUS, 0);
            chk("mode status", q, {30'h0000_0000, e, e});
            wb(0, PPS_OFS_VALUE, 0);
            chk("mode value", q, v);
            wb(1, PPS_OFS_CTRL, 0);
         end
      end
      $display("mode test done");
      wb(1, PPS_OFS_PICKUP, 100);
      wb(1, PPS_OFS_HYST, 10);
      wb(1, PPS_OFS_DELAY, 1);
      foreach (per_q[t])
      begin
         wb(0, PPS_OFS_IRQ, 0);
         wb(1, PPS_OFS_MASK, t == 2 ? 0 : 7);
         u_meas.put(3, 150);
         wb(1, PPS_OFS_CTRL, 1 | t << 3 | 3 << 8);
         n = 0;
         while (start !== 1'b1 && n < 300)
         begin
            @(posedge ref_clk);
            n++;
         end
         n = 0;
         while (trip !== 1'b1 && n < 300)
         begin
            @(posedge ref_clk);
            n++;
         end
         chk("trip delay", n, per_q[t]);
         u_meas.put(3, 95);
         repeat (3 * per_q[t]) @(posedge ref_clk);
         chk("hold in band", start, 1);
         u_meas.put(3, 85);
         repeat (3 * per_q[t]) @(posedge ref_clk);
         chk("released", {trip, start}, 0);
         chk("irq line", irq, t != 2);
         wb(0, PPS_OFS_IRQ, 0);
         chk("irq bits", q, 7);
         wb(0, PPS_OFS_IRQ, 0);
         chk("irq cleared", q, 0);
         chk("irq low", irq, 0);
         wb(1, PPS_OFS_CTRL, 0);
      end
      $display("timing test done");
      end_sim();
   end
endmodule
`default_nettype wire
